// *** hw/inc_exec.sv ***
/*
  inc_exec: executes the three increment instructions of the core,
  with an axi4-lite slave for bank, working register, flags and mode.
  assumes: one instruction offered at a time on instr_valid while
  instr_ready is high; file_rdata valid one cycle after file_re.
*/
// How it works
// - plain increment adds one to the file byte and updates five flags
// - destination bit zero writes the working register, one writes back
// - access bit zero uses the access bank, one uses the bank register
// - access zero with extended mode and offset up to 95 adds index base
// - skip-on-zero increments without flags, discards next if zero
// - skip-on-nonzero increments without flags, discards next if nonzero
// - any eight-bit address and both operand bits are accepted
`timescale 1ns/1ps
module inc_exec (
  input wire logic mclk,
  input wire logic rst,
  input wire logic instr_valid,
  input wire logic [15:0] instr,
  output logic instr_ready,
  output logic [11:0] file_addr,
  output logic file_re,
  input wire logic [7:0] file_rdata,
  output logic file_we,
  output logic [7:0] file_wdata,
  output logic discard,
  input wire logic [4:0] s_awaddr,
  input wire logic s_awvalid,
  output logic s_awready,
  input wire logic [31:0] s_wdata,
  input wire logic [3:0] s_wstrb,
  input wire logic s_wvalid,
  output logic s_wready,
  output logic [1:0] s_bresp,
  output logic s_bvalid,
  input wire logic s_bready,
  input wire logic [4:0] s_araddr,
  input wire logic s_arvalid,
  output logic s_arready,
  output logic [31:0] s_rdata,
  output logic [1:0] s_rresp,
  output logic s_rvalid,
  input wire logic s_rready
);
  typedef enum logic [3:0] {
    S_IDLE = 4'b0001,
    S_RD = 4'b0010,
    S_EX = 4'b0100,
    S_NOP = 4'b1000
  } state_e;

  typedef struct packed {
    state_e st;
    logic [1:0] kind;
    logic dbit;
    logic [11:0] addr;
    logic rdy;
    logic re;
    logic we;
    logic [7:0] wdata;
    logic discard;
    logic ext_en;
    logic [3:0] bank;
    logic [7:0] wreg;
    logic [4:0] flags;
    logic [11:0] index;
    logic [7:0] last_res;
    logic last_skip;
    logic aw_h;
    logic [4:0] awa;
    logic w_h;
    logic [31:0] wd;
    logic [3:0] ws;
    logic awrdy;
    logic wrdy;
    logic bvalid;
    logic [1:0] bresp;
    logic arrdy;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
  } st_s;

  st_s s_r;
  st_s s_nxt;
  logic [7:0] alu_res;
  logic [4:0] alu_flags;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // opcode to kind of work
  function automatic logic [1:0] kind_of(input logic [5:0] opc);
    case (opc)
      inc_pkg::OP_INC: kind_of = inc_pkg::K_INC;
      inc_pkg::OP_INZ: kind_of = inc_pkg::K_INZ;
      inc_pkg::OP_INNZ: kind_of = inc_pkg::K_INNZ;
      default: kind_of = inc_pkg::K_NONE;
    endcase
  endfunction

  // register map decode, shared by read and write paths
  function automatic logic mapped(input logic [4:0] a);
    mapped = (a == inc_pkg::R_CTRL) || (a == inc_pkg::R_BANK) || (a == inc_pkg::R_WREG)
      || (a == inc_pkg::R_FLAGS) || (a == inc_pkg::R_INDEX) || (a == inc_pkg::R_INFO);
  endfunction

  // full 12-bit operand address from f, a, bank and mode
  function automatic logic [11:0] eff_addr(input logic [7:0] f, input logic a,
                                           input logic ext, input logic [3:0] bank,
                                           input logic [11:0] idx);
    if (a) begin
      eff_addr = {bank, f};
    end else if (ext && (f <= inc_pkg::IDX_LIMIT)) begin
      eff_addr = idx + {4'h0, f};
    end else if (f < inc_pkg::ACC_SPLIT) begin
      eff_addr = {inc_pkg::ACC_LO_BANK, f};
    end else begin
      eff_addr = {inc_pkg::ACC_HI_BANK, f};
    end
  endfunction

  inc_alu u_alu (
    .opnd(file_rdata),
    .res(alu_res),
    .flags(alu_flags)
  );

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  // execution sequence, then the register slave
  always_comb begin
    logic skip;
    logic [31:0] rv;
    skip = 1'b0;
    rv = '0;
    s_nxt = s_r;
    s_nxt.re = 1'b0;
    s_nxt.we = 1'b0;
    s_nxt.discard = 1'b0;
    case (s_r.st)
      S_IDLE: begin
        if (instr_valid) begin
          s_nxt.kind = kind_of(instr[inc_pkg::OPC_HI:inc_pkg::OPC_LO]);
          s_nxt.dbit = instr[inc_pkg::DEST_BIT];
          // every f of 0..255 with any d and a is legal
          s_nxt.addr = eff_addr(instr[inc_pkg::ADDR_HI:0], instr[inc_pkg::ACC_BIT],
                                s_r.ext_en, s_r.bank, s_r.index);
          if (s_nxt.kind != inc_pkg::K_NONE) begin
            s_nxt.st = S_RD;
            s_nxt.re = 1'b1;
          end
        end
      end
      S_RD: begin
        s_nxt.st = S_EX;
      end
      S_EX: begin
        s_nxt.last_res = alu_res;
        if (s_r.dbit) begin
          s_nxt.we = 1'b1;
          s_nxt.wdata = alu_res;
        end else begin
          s_nxt.wreg = alu_res;
        end
        if (s_r.kind == inc_pkg::K_INC) begin
          s_nxt.flags = alu_flags;
        end
        skip = ((s_r.kind == inc_pkg::K_INZ) && (alu_res == 8'h00))
          || ((s_r.kind == inc_pkg::K_INNZ) && (alu_res != 8'h00));
        s_nxt.last_skip = skip;
        s_nxt.discard = skip;
        s_nxt.st = skip ? S_NOP : S_IDLE;
      end
      S_NOP: begin
        s_nxt.st = S_IDLE;                     // no-operation in the second cycle
      end
      default: begin
        s_nxt.st = S_IDLE;
      end
    endcase
    // write address and data land in either order
    if (s_awvalid && s_r.awrdy) begin
      s_nxt.aw_h = 1'b1;
      s_nxt.awa = s_awaddr;
    end
    if (s_wvalid && s_r.wrdy) begin
      s_nxt.w_h = 1'b1;
      s_nxt.wd = s_wdata;
      s_nxt.ws = s_wstrb;
    end
    if (s_r.bvalid && s_bready) begin
      s_nxt.bvalid = 1'b0;
    end
    if (s_r.aw_h && s_r.w_h && !s_r.bvalid) begin
      s_nxt.aw_h = 1'b0;
      s_nxt.w_h = 1'b0;
      s_nxt.bvalid = 1'b1;
      s_nxt.bresp = mapped(s_r.awa) ? inc_pkg::RESP_OK : inc_pkg::RESP_ERR;
      // software loses to a hardware update in the same cycle
      if (s_r.ws[0]) begin
        case (s_r.awa)
          inc_pkg::R_CTRL: s_nxt.ext_en = s_r.wd[0];
          inc_pkg::R_BANK: s_nxt.bank = s_r.wd[3:0];
          inc_pkg::R_WREG: if (s_r.st != S_EX) s_nxt.wreg = s_r.wd[7:0];
          inc_pkg::R_FLAGS: if (s_r.st != S_EX) s_nxt.flags = s_r.wd[4:0];
          inc_pkg::R_INDEX: s_nxt.index[7:0] = s_r.wd[7:0];
          default: s_nxt.ext_en = s_r.ext_en;
        endcase
      end
      if (s_r.ws[1] && (s_r.awa == inc_pkg::R_INDEX)) begin
        s_nxt.index[11:8] = s_r.wd[11:8];
      end
    end
    // read channel
    if (s_r.rvalid && s_rready) begin
      s_nxt.rvalid = 1'b0;
    end
    if (s_arvalid && s_r.arrdy) begin
      case (s_araddr)
        inc_pkg::R_CTRL: rv = {31'h0000_0000, s_r.ext_en};
        inc_pkg::R_BANK: rv = {28'h000_0000, s_r.bank};
        inc_pkg::R_WREG: rv = {24'h00_0000, s_r.wreg};
        inc_pkg::R_FLAGS: rv = {27'h000_0000, s_r.flags};
        inc_pkg::R_INDEX: rv = {20'h0_0000, s_r.index};
        inc_pkg::R_INFO: rv = {22'h00_0000, s_r.last_skip, s_r.st != S_IDLE, s_r.last_res};
        default: rv = '0;
      endcase
      s_nxt.rvalid = 1'b1;
      s_nxt.rdata = rv;
      s_nxt.rresp = mapped(s_araddr) ? inc_pkg::RESP_OK : inc_pkg::RESP_ERR;
    end
    s_nxt.awrdy = !s_nxt.aw_h;
    s_nxt.wrdy = !s_nxt.w_h;
    s_nxt.arrdy = !s_nxt.rvalid;
    s_nxt.rdy = (s_nxt.st == S_IDLE);
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  // reset leaves both slots empty and the unit idle
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      s_r <= '0;
      s_r.st <= S_IDLE;
      s_r.rdy <= 1'b1;
      s_r.awrdy <= 1'b1;
      s_r.wrdy <= 1'b1;
      s_r.arrdy <= 1'b1;
      s_r.wreg <= inc_pkg::WREG_RST;
      s_r.index <= inc_pkg::INDEX_RST;
    end else begin
      s_r <= s_nxt;
    end
  end

  // outputs straight from the state flops
  assign instr_ready = s_r.rdy;
  assign file_addr = s_r.addr;
  assign file_re = s_r.re;
  assign file_we = s_r.we;
  assign file_wdata = s_r.wdata;
  assign discard = s_r.discard;
  assign s_awready = s_r.awrdy;
  assign s_wready = s_r.wrdy;
  assign s_bvalid = s_r.bvalid;
  assign s_bresp = s_r.bresp;
  assign s_arready = s_r.arrdy;
  assign s_rvalid = s_r.rvalid;
  assign s_rdata = s_r.rdata;
  assign s_rresp = s_r.rresp;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  sequence ex_seq;
    s_r.st == S_RD ##1 s_r.st == S_EX;
  endsequence

  sequence skip_seq;
    discard && s_r.st == S_NOP ##1 s_r.st == S_IDLE;
  endsequence

  inc_res_a: assert property (@(posedge mclk) disable iff (rst)
    ex_seq ##1 (s_r.kind != inc_pkg::K_NONE) |-> s_r.last_res == $past(file_rdata) + 8'h01)
    else $error("increment result wrong");
  flag_upd_a: assert property (@(posedge mclk) disable iff (rst)
    (s_r.st == S_EX && s_r.kind == inc_pkg::K_INC) |=> s_r.flags[inc_pkg::F_Z]
      == (s_r.last_res == 8'h00))
    else $error("zero flag wrong");
  dest_wr_a: assert property (@(posedge mclk) disable iff (rst)
    (s_r.st == S_EX) |=> file_we == $past(s_r.dbit))
    else $error("destination routing wrong");
  bank_sel_a: assert property (@(posedge mclk) disable iff (rst)
    (s_r.st == S_IDLE && instr_valid && instr[inc_pkg::ACC_BIT]
      && kind_of(instr[15:10]) != inc_pkg::K_NONE) |=> file_addr[11:8] == $past(s_r.bank))
    else $error("bank select wrong");
  idx_mode_a: assert property (@(posedge mclk) disable iff (rst)
    (s_r.st == S_IDLE && instr_valid && !instr[inc_pkg::ACC_BIT] && s_r.ext_en
      && instr[7:0] <= inc_pkg::IDX_LIMIT && kind_of(instr[15:10]) != inc_pkg::K_NONE)
      |=> file_addr == $past(s_r.index) + {4'h0, $past(instr[7:0])})
    else $error("indexed address wrong");
  skip_zero_a: assert property (@(posedge mclk) disable iff (rst)
    (s_r.st == S_EX && s_r.kind == inc_pkg::K_INZ && alu_res == 8'h00) |=> skip_seq)
    else $error("zero skip missing");
  skip_nz_a: assert property (@(posedge mclk) disable iff (rst)
    (s_r.st == S_EX && s_r.kind == inc_pkg::K_INNZ) |=> discard == (s_r.last_res != 8'h00))
    else $error("nonzero skip wrong");
  skip_flags_a: assert property (@(posedge mclk) disable iff (rst)
    (s_r.st == S_EX && s_r.kind != inc_pkg::K_INC && !(s_r.bvalid == 1'b0 && s_r.aw_h
      && s_r.w_h)) |=> $stable(s_r.flags))
    else $error("skip form touched flags");
  any_addr_a: assert property (@(posedge mclk) disable iff (rst)
    (instr_ready && instr_valid && kind_of(instr[15:10]) != inc_pkg::K_NONE)
      |=> file_re ##1 !instr_ready)
    else $error("legal operand refused");
endmodule

// *** hw/inc_pkg.sv ***
/*
  package: opcodes, operand fields, register map, flag positions and
  address windows for the increment execution block.
  assumes: nothing beyond a SystemVerilog compiler.
*/
package inc_pkg;
  // ----------------------------------------------------------------
  // instruction fields
  // ----------------------------------------------------------------
  localparam logic [5:0] OP_INC = 6'h0A;   // 0010 10da
  localparam logic [5:0] OP_INZ = 6'h0F;   // 0011 11da
  localparam logic [5:0] OP_INNZ = 6'h12;  // 0100 10da
  localparam int OPC_HI = 15;
  localparam int OPC_LO = 10;
  localparam int DEST_BIT = 9;
  localparam int ACC_BIT = 8;
  localparam int ADDR_HI = 7;
  localparam logic [7:0] IDX_LIMIT = 8'h5F;  // 95, highest indexed offset
  localparam logic [7:0] ACC_SPLIT = 8'h60;  // low access ram below this
  localparam logic [3:0] ACC_HI_BANK = 4'hF;
  localparam logic [3:0] ACC_LO_BANK = 4'h0;
  // ----------------------------------------------------------------
  // kinds of work
  // ----------------------------------------------------------------
  localparam logic [1:0] K_NONE = 2'h0;
  localparam logic [1:0] K_INC = 2'h1;
  localparam logic [1:0] K_INZ = 2'h2;
  localparam logic [1:0] K_INNZ = 2'h3;
  // ----------------------------------------------------------------
  // flag positions in the status register
  // ----------------------------------------------------------------
  localparam int F_C = 0;
  localparam int F_DC = 1;
  localparam int F_Z = 2;
  localparam int F_OV = 3;
  localparam int F_N = 4;
  localparam int FLAG_W = 5;
  // ----------------------------------------------------------------
  // register map, byte addresses
  // ----------------------------------------------------------------
  localparam int AW = 5;
  localparam logic [4:0] R_CTRL = 5'h00;
  localparam logic [4:0] R_BANK = 5'h04;
  localparam logic [4:0] R_WREG = 5'h08;
  localparam logic [4:0] R_FLAGS = 5'h0C;
  localparam logic [4:0] R_INDEX = 5'h10;
  localparam logic [4:0] R_INFO = 5'h14;
  localparam logic [1:0] RESP_OK = 2'h0;
  localparam logic [1:0] RESP_ERR = 2'h2;
  localparam logic [7:0] WREG_RST = 8'h00;
  localparam logic [11:0] INDEX_RST = 12'h000;
endpackage

// *** hw/inc_alu.sv ***
/*
  inc_alu: adds one to an operand byte and works out the flags.
  assumes: purely combinational, driven by the execution unit.
*/
`timescale 1ns/1ps
module inc_alu (
  input wire logic [7:0] opnd,
  output logic [7:0] res,
  output logic [4:0] flags
);
  // ----------------------------------------------------------------
  // increment and flag rules
  // ----------------------------------------------------------------
  // carry out of bit 7 and bit 3, signed wrap from 7f
  always_comb begin
    res = opnd + 8'h01;
    flags = '0;
    flags[inc_pkg::F_C] = (opnd == 8'hFF);
    flags[inc_pkg::F_DC] = (opnd[3:0] == 4'hF);
    flags[inc_pkg::F_Z] = (res == 8'h00);
    flags[inc_pkg::F_OV] = (opnd == 8'h7F);
    flags[inc_pkg::F_N] = res[7];
  end
endmodule

// *** test/increment_skip_instr_exec_tb.sv ***
/*
  increment_skip_instr_exec_tb: self-checking bench for the increment execution block.
  assumes: inc_pkg and inc_exec compiled first; the bench plays core, file ram and bus master.
*/
`timescale 1ns/1ps
module increment_skip_instr_exec_tb;
  logic mclk, rst, instr_valid, instr_ready, file_re, file_we, discard;
  logic [15:0] instr;
  logic [11:0] file_addr;
  logic [7:0] file_rdata, file_wdata;
  logic [4:0] s_awaddr, s_araddr;
  logic [31:0] s_wdata, s_rdata, rd;
  logic [3:0] s_wstrb;
  logic [1:0] s_bresp, s_rresp, rr;
  logic s_awvalid, s_awready, s_wvalid, s_wready, s_bvalid, s_bready;
  logic s_arvalid, s_arready, s_rvalid, s_rready;
  logic [3:0] bank_s;
  logic [11:0] idx_s;
  logic [7:0] wreg_s;
  logic [4:0] flags_s;
  int miscompares = 0;
  int compares = 0;
  int idle_bad;

  inc_exec dut (.mclk(mclk), .rst(rst), .instr_valid(instr_valid), .instr(instr),
    .instr_ready(instr_ready), .file_addr(file_addr), .file_re(file_re),
    .file_rdata(file_rdata), .file_we(file_we), .file_wdata(file_wdata), .discard(discard),
    .s_awaddr(s_awaddr), .s_awvalid(s_awvalid), .s_awready(s_awready), .s_wdata(s_wdata),
    .s_wstrb(s_wstrb), .s_wvalid(s_wvalid), .s_wready(s_wready), .s_bresp(s_bresp),
    .s_bvalid(s_bvalid), .s_bready(s_bready), .s_araddr(s_araddr), .s_arvalid(s_arvalid),
    .s_arready(s_arready), .s_rdata(s_rdata), .s_rresp(s_rresp), .s_rvalid(s_rvalid),
    .s_rready(s_rready));

  // ----------------------------------------------------------------
  // clock, compare and verdict
  // ----------------------------------------------------------------
  // 125 MHz clock
  initial mclk = 1'b0;
  always #4 mclk = ~mclk;

  // one compare with case equality
  task check(input logic [31:0] got, input logic [31:0] exp, input string what);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  // counts, verdict and end of run
  task results();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // axi4-lite master tasks
  // ----------------------------------------------------------------
  // address and data offered together, each dropped at its own handshake
  task axi_write(input logic [4:0] addr, input logic [31:0] data, output logic [1:0] resp);
    logic aw_p, w_p, aw_hit, w_hit;
    aw_p = 1'b1;
    w_p = 1'b1;
    @(posedge mclk);
    s_awaddr <= addr;
    s_awvalid <= 1'b1;
    s_wdata <= data;
    s_wstrb <= 4'hF;
    s_wvalid <= 1'b1;
    s_bready <= 1'b1;
    do begin
      @(negedge mclk);
      aw_hit = aw_p && (s_awready === 1'b1);
      w_hit = w_p && (s_wready === 1'b1);
      @(posedge mclk);
      if (aw_hit) begin
        s_awvalid <= 1'b0;
        aw_p = 1'b0;
      end
      if (w_hit) begin
        s_wvalid <= 1'b0;
        w_p = 1'b0;
      end
    end while (aw_p || w_p);
    do @(negedge mclk); while (s_bvalid !== 1'b1);
    resp = s_bresp;
    @(posedge mclk);
    s_bready <= 1'b0;
  endtask

  // read address, then wait for the data beat
  task axi_read(input logic [4:0] addr, output logic [31:0] data, output logic [1:0] resp);
    @(posedge mclk);
    s_araddr <= addr;
    s_arvalid <= 1'b1;
    s_rready <= 1'b1;
    do @(negedge mclk); while (s_arready !== 1'b1);
    @(posedge mclk);
    s_arvalid <= 1'b0;
    do @(negedge mclk); while (s_rvalid !== 1'b1);
    data = s_rdata;
    resp = s_rresp;
    @(posedge mclk);
    s_rready <= 1'b0;
  endtask

  // ----------------------------------------------------------------
  // one increment instruction with its expected effects
  // ----------------------------------------------------------------
  task exec(input logic [5:0] op, input logic d, input logic a, input logic [7:0] f,
            input logic [7:0] v, input logic ext);
    logic [11:0] ea, ga;
    logic [7:0] res, gw;
    logic [4:0] nf;
    logic skip;
    int re_n, we_n, dis_n, rdy_n;
    axi_write(inc_pkg::R_CTRL, {31'h0000_0000, ext}, rr);
    res = v + 8'h01;
    skip = (op == inc_pkg::OP_INZ) ? (res == 8'h00) :
           (op == inc_pkg::OP_INNZ) ? (res != 8'h00) : 1'b0;
    if (a) ea = {bank_s, f};
    else if (ext && f <= inc_pkg::IDX_LIMIT) ea = idx_s + {4'h0, f};
    else if (f < inc_pkg::ACC_SPLIT) ea = {inc_pkg::ACC_LO_BANK, f};
    else ea = {inc_pkg::ACC_HI_BANK, f};
    nf = flags_s;
    if (op == inc_pkg::OP_INC) begin
      nf[inc_pkg::F_C] = (v == 8'hFF);
      nf[inc_pkg::F_DC] = (v[3:0] == 4'hF);
      nf[inc_pkg::F_Z] = (res == 8'h00);
      nf[inc_pkg::F_OV] = (v == 8'h7F);
      nf[inc_pkg::F_N] = res[7];
    end
    re_n = 0;
    we_n = 0;
    dis_n = 0;
    rdy_n = 0;
    ga = 12'h000;
    gw = 8'h00;
    @(posedge mclk);
    instr_valid <= 1'b1;
    instr <= {op, d, a, f};
    file_rdata <= v;
    do @(negedge mclk); while (instr_ready !== 1'b1);
    @(posedge mclk);
    instr_valid <= 1'b0;
    // watch the cycles after the take, ram data dropped once used
    for (int n = 1; n <= 7; n++) begin
      @(negedge mclk);
      if (file_re === 1'b1 && re_n == 0) begin
        re_n = n;
        ga = file_addr;
      end
      if (file_we === 1'b1 && we_n == 0) begin
        we_n = n;
        gw = file_wdata;
      end
      if (discard === 1'b1 && dis_n == 0) dis_n = n;
      if (instr_ready === 1'b1 && rdy_n == 0) rdy_n = n;
      if (n == 3) file_rdata <= ~v;
    end
    check(re_n, 1, "read strobe cycle");
    check(ga, ea, "operand address");
    check(we_n, d ? 3 : 0, "write strobe cycle");
    if (d) check(gw, res, "write back data");
    check(dis_n, skip ? 3 : 0, "discard pulse");
    check(rdy_n, skip ? 4 : 3, "cycles taken");
    if (!d) wreg_s = res;
    flags_s = nf;
    axi_read(inc_pkg::R_WREG, rd, rr);
    check(rd, {24'h00_0000, wreg_s}, "working register");
    axi_read(inc_pkg::R_FLAGS, rd, rr);
    check(rd, {27'h000_0000, flags_s}, "flags");
  endtask

  // ----------------------------------------------------------------
  // watchdog and main sequence
  // ----------------------------------------------------------------
  // cuts a hang short well past the expected few hundred cycles
  initial begin
    #200_000;
    miscompares++;
    $display("[FAIL] t=%0t watchdog expired", $time);
    results();
  end

  // reset, register checks, then the instruction list
  initial begin
    rst = 1'b1;
    instr_valid = 1'b0;
    instr = 16'h0000;
    file_rdata = 8'h00;
    s_awaddr = 5'h00;
    s_awvalid = 1'b0;
    s_wdata = 32'h0000_0000;
    s_wstrb = 4'h0;
    s_wvalid = 1'b0;
    s_bready = 1'b0;
    s_araddr = 5'h00;
    s_arvalid = 1'b0;
    s_rready = 1'b0;
    repeat (8) @(posedge mclk);
    rst <= 1'b0;
    axi_read(inc_pkg::R_WREG, rd, rr);
    check(rd, {24'h00_0000, inc_pkg::WREG_RST}, "wreg reset");
    axi_read(inc_pkg::R_INDEX, rd, rr);
    check(rd, {20'h0_0000, inc_pkg::INDEX_RST}, "index reset");
    axi_read(5'h18, rd, rr);
    check(rr, inc_pkg::RESP_ERR, "unmapped read resp");
    check(rd, 32'h0000_0000, "unmapped read data");
    axi_write(5'h1C, 32'h0000_0055, rr);
    check(rr, inc_pkg::RESP_ERR, "unmapped write resp");
    axi_write(inc_pkg::R_BANK, 32'h0000_0005, rr);
    check(rr, inc_pkg::RESP_OK, "bank write resp");
    axi_read(inc_pkg::R_BANK, rd, rr);
    check(rd, 32'h0000_0005, "bank readback");
    axi_write(inc_pkg::R_INDEX, 32'h0000_0FF0, rr);
    axi_write(inc_pkg::R_FLAGS, 32'h0000_0015, rr);
    axi_write(inc_pkg::R_WREG, 32'h0000_00A5, rr);
    bank_s = 4'h5;
    idx_s = 12'hFF0;
    flags_s = 5'h15;
    wreg_s = 8'hA5;
    $display("test registers done");
    exec(inc_pkg::OP_INC, 1'b1, 1'b1, 8'hFF, 8'hFF, 1'b0);
    exec(inc_pkg::OP_INC, 1'b0, 1'b1, 8'h00, 8'h7F, 1'b0);
    exec(inc_pkg::OP_INC, 1'b1, 1'b0, 8'h5F, 8'h0F, 1'b0);
    exec(inc_pkg::OP_INC, 1'b1, 1'b0, 8'h60, 8'h00, 1'b0);
    exec(inc_pkg::OP_INC, 1'b0, 1'b0, 8'h5F, 8'h01, 1'b1);
    exec(inc_pkg::OP_INC, 1'b1, 1'b0, 8'h60, 8'h02, 1'b1);
    exec(inc_pkg::OP_INZ, 1'b1, 1'b1, 8'h10, 8'hFF, 1'b0);
    exec(inc_pkg::OP_INZ, 1'b0, 1'b0, 8'h00, 8'h10, 1'b1);
    exec(inc_pkg::OP_INNZ, 1'b1, 1'b1, 8'h80, 8'hFF, 1'b0);
    exec(inc_pkg::OP_INNZ, 1'b0, 1'b1, 8'h01, 8'h00, 1'b0);
    // last result 01, skip taken, unit idle
    axi_read(inc_pkg::R_INFO, rd, rr);
    check(rd, 32'h0000_0201, "info after skip");
    // an opcode outside the three is consumed without any strobe
    @(posedge mclk);
    instr_valid <= 1'b1;
    instr <= 16'h0000;
    @(posedge mclk);
    instr_valid <= 1'b0;
    idle_bad = 0;
    repeat (4) begin
      @(negedge mclk);
      if (file_re !== 1'b0 || file_we !== 1'b0 || instr_ready !== 1'b1) idle_bad++;
    end
    check(idle_bad, 0, "unknown opcode ignored");
    $display("test increments done");
    results();
  end
endmodule
